// ### verilog/slpmc_controller.v
// sleep mode power controller: mode decode, clock gating, wake qualification
//
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "slpmc_consts.vh"
module slpmc_controller #(
    parameter [`SLPMC_CNT_W-1:0] STARTUP_CYCLES = `SLPMC_STARTUP_DEFAULT
) (
    input  wire        mclk,
    input  wire        reset,
    input  wire [3:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_write,
    input  wire        reg_read,
    output reg  [7:0]  reg_rdata,
    input  wire        sleep_instr,
    input  wire        irq_pending,
    input  wire        ext_irq_lower,
    input  wire        ext_irq_upper_level,
    input  wire        pin_change_irq,
    input  wire        usb_wake_irq,
    input  wire        twi_addr_match,
    input  wire        crystal_selected,
    input  wire        debug_enable_fuse,
    input  wire        brownout_fuse_en,
    input  wire        watchdog_enabled,
    input  wire        comparator_int_ref,
    output reg         cpu_clock_en,
    output reg         flash_clock_en,
    output reg         io_clock_en,
    output reg         osc_en,
    output reg         cpu_halt,
    output reg         wake_irq_take,
    output reg  [7:0]  periph_clock_en_0,
    output reg  [7:0]  periph_clock_en_1,
    output reg  [7:0]  periph_reg_block_0,
    output reg  [7:0]  periph_reg_block_1,
    output reg         comparator_disable,
    output reg         int_ref_keep,
    output reg         brownout_keep,
    output reg         watchdog_keep,
    output reg         input_buf_en,
    output reg         wake_pin_buf_en
);

    localparam ST_ACTIVE = 2'h0;
    localparam ST_SLEEP  = 2'h1;
    localparam ST_WAKE   = 2'h2;
    localparam ST_HALT   = 2'h3;

    ////////////////////////////////////////////////////////////////////////
    // pin-side wake sources pass two flops
    reg [4:0] wake_meta;
    reg [4:0] wake_sync;

    always @(posedge mclk) begin
        if (reset) begin
            wake_meta <= 5'h00;
            wake_sync <= 5'h00;
        end else begin
            wake_meta <= {twi_addr_match, usb_wake_irq, pin_change_irq,
                          ext_irq_upper_level, ext_irq_lower};
            wake_sync <= wake_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers
    reg [7:0] sleep_control_reg;
    reg [7:0] periph_clock_stop_0;
    reg [7:0] periph_clock_stop_1;
    reg [1:0] state;
    reg [1:0] next_state;
    reg [2:0] active_mode;

    wire       sleep_arm      = sleep_control_reg[`SLPMC_ARM_BIT];
    wire [2:0] sleep_mode_sel = sleep_control_reg[`SLPMC_MODE_MSB:`SLPMC_MODE_LSB];

    always @(posedge mclk) begin
        if (reset) begin
            sleep_control_reg   <= `SLPMC_SLEEP_CTRL_RESET;
            periph_clock_stop_0 <= `SLPMC_STOP0_RESET;
            periph_clock_stop_1 <= `SLPMC_STOP1_RESET;
        end else if (reg_write) begin
            case (reg_addr)
                `SLPMC_ADDR_SLEEP_CTRL: sleep_control_reg   <= {4'h0, reg_wdata[3:0]};
                `SLPMC_ADDR_STOP0:      periph_clock_stop_0 <= reg_wdata & `SLPMC_STOP0_MASK;
                `SLPMC_ADDR_STOP1:      periph_clock_stop_1 <= reg_wdata & `SLPMC_STOP1_MASK;
                default: begin
                end
            endcase
        end
    end

    always @(posedge mclk) begin
        if (reset) begin
            reg_rdata <= 8'h00;
        end else if (reg_read) begin
            case (reg_addr)
                `SLPMC_ADDR_SLEEP_CTRL: reg_rdata <= sleep_control_reg;
                `SLPMC_ADDR_STOP0:      reg_rdata <= periph_clock_stop_0;
                `SLPMC_ADDR_STOP1:      reg_rdata <= periph_clock_stop_1;
                `SLPMC_ADDR_STATUS:     reg_rdata <= {3'h0, active_mode, state};
                default:                reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // mode decode
    // standby codes fall back to power-down without a crystal, so the
    // oscillator runs for a source that cannot use it only while debug_enable_fuse is set
    function [2:0] resolve_mode;
        input [2:0] sel;
        input       xtal;
        begin
            case (sel)
                `SLPMC_MODE_IDLE:        resolve_mode = `SLPMC_MODE_IDLE;
                `SLPMC_MODE_PDOWN:       resolve_mode = `SLPMC_MODE_PDOWN;
                `SLPMC_MODE_PSAVE:       resolve_mode = `SLPMC_MODE_PDOWN;
                `SLPMC_MODE_STANDBY:     resolve_mode = xtal ? `SLPMC_MODE_STANDBY
                                                             : `SLPMC_MODE_PDOWN;
                `SLPMC_MODE_EXT_STANDBY: resolve_mode = xtal ? `SLPMC_MODE_STANDBY
                                                             : `SLPMC_MODE_PDOWN;
                // reserved codes sleep as power-down, the deepest safe choice
                default:                 resolve_mode = `SLPMC_MODE_PDOWN;
            endcase
        end
    endfunction

    wire enter_sleep = sleep_instr && sleep_arm && (state == ST_ACTIVE);

    wire deep_wake = |wake_sync;
    wire idle_wake = irq_pending || deep_wake;
    wire wake_now  = (active_mode == `SLPMC_MODE_IDLE) ? idle_wake : deep_wake;

    ////////////////////////////////////////////////////////////////////////
    // wake delay
    reg                     timer_load;
    reg [`SLPMC_CNT_W-1:0]  timer_value;
    wire                    timer_done;

    always @* begin
        timer_load  = 1'b0;
        timer_value = {`SLPMC_CNT_W{1'b0}};
        if (state == ST_SLEEP && wake_now) begin
            timer_load = 1'b1;
            case (active_mode)
                `SLPMC_MODE_IDLE:    timer_value = {{(`SLPMC_CNT_W-8){1'b0}}, 8'h01};
                `SLPMC_MODE_STANDBY: timer_value = {{(`SLPMC_CNT_W-8){1'b0}}, `SLPMC_STANDBY_WAKE};
                default:             timer_value = STARTUP_CYCLES;
            endcase
        end else if (state == ST_WAKE && timer_done) begin
            timer_load  = 1'b1;
            timer_value = {{(`SLPMC_CNT_W-8){1'b0}}, `SLPMC_HALT_EXTRA_CYCLES};
        end
    end

    slpmc_wake_timer #(
        .CNT_W      (`SLPMC_CNT_W)
    ) u_timer (
        .mclk       (mclk),
        .reset      (reset),
        .load       (timer_load),
        .load_value (timer_value),
        .done       (timer_done)
    );

    ////////////////////////////////////////////////////////////////////////
    // sleep state machine; any reset returns to active and the cpu
    // restarts at its vector, it never resumes after the sleep
    always @* begin
        case (state)
            ST_ACTIVE: next_state = enter_sleep ? ST_SLEEP : ST_ACTIVE;
            ST_SLEEP:  next_state = wake_now ? ST_WAKE : ST_SLEEP;
            ST_WAKE:   next_state = timer_done ? ST_HALT : ST_WAKE;
            ST_HALT:   next_state = timer_done ? ST_ACTIVE : ST_HALT;
            default:   next_state = ST_ACTIVE;
        endcase
    end

    always @(posedge mclk) begin
        if (reset) begin
            state       <= ST_ACTIVE;
            active_mode <= `SLPMC_MODE_IDLE;
        end else begin
            state <= next_state;
            if (enter_sleep) begin
                active_mode <= resolve_mode(sleep_mode_sel, crystal_selected);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // clock and analog gating; only clocks, comparator and input buffers are gated, no storage is
    // cleared, so register file and ram keep their contents
    wire asleep  = (state == ST_SLEEP) || (state == ST_WAKE);
    wire deep    = asleep && (active_mode != `SLPMC_MODE_IDLE);
    wire osc_off = deep && (active_mode != `SLPMC_MODE_STANDBY);

    genvar i;
    generate
        for (i = 0; i < 8; i = i + 1) begin : g_periph
            always @(posedge mclk) begin
                if (reset) begin
                    periph_clock_en_0[i]  <= 1'b1;
                    periph_clock_en_1[i]  <= 1'b1;
                    periph_reg_block_0[i] <= 1'b0;
                    periph_reg_block_1[i] <= 1'b0;
                end else begin
                    periph_clock_en_0[i]  <= !periph_clock_stop_0[i] && !deep;
                    periph_clock_en_1[i]  <= !periph_clock_stop_1[i] && !deep;
                    periph_reg_block_0[i] <= periph_clock_stop_0[i];
                    periph_reg_block_1[i] <= periph_clock_stop_1[i];
                end
            end
        end
    endgenerate

    always @(posedge mclk) begin
        if (reset) begin
            cpu_clock_en       <= 1'b1;
            flash_clock_en     <= 1'b1;
            io_clock_en        <= 1'b1;
            osc_en             <= 1'b1;
            cpu_halt           <= 1'b0;
            wake_irq_take      <= 1'b0;
            comparator_disable <= 1'b0;
            int_ref_keep       <= 1'b0;
            brownout_keep      <= 1'b0;
            watchdog_keep      <= 1'b0;
            input_buf_en       <= 1'b1;
            wake_pin_buf_en    <= 1'b1;
        end else begin
            cpu_clock_en       <= !asleep && next_state != ST_SLEEP;
            flash_clock_en     <= !asleep && next_state != ST_SLEEP;
            io_clock_en        <= !deep;
            osc_en             <= !osc_off || debug_enable_fuse;
            // from the next state so the halt drops together with the take pulse
            cpu_halt           <= next_state != ST_ACTIVE;
            wake_irq_take      <= state == ST_HALT && timer_done;
            comparator_disable <= deep && !comparator_int_ref;
            int_ref_keep       <= deep && comparator_int_ref;
            brownout_keep      <= brownout_fuse_en;
            watchdog_keep      <= watchdog_enabled;
            input_buf_en       <= !deep;
            wake_pin_buf_en    <= 1'b1;
        end
    end
endmodule

// ### verilog/slpmc_consts.vh
// constants for the sleep mode power controller
`ifndef SLPMC_CONSTS_VH
`define SLPMC_CONSTS_VH

`define SLPMC_ADDR_SLEEP_CTRL   4'h0
`define SLPMC_ADDR_STOP0        4'h1
`define SLPMC_ADDR_STOP1        4'h2
`define SLPMC_ADDR_STATUS       4'h3

`define SLPMC_ARM_BIT           0
`define SLPMC_MODE_LSB          1
`define SLPMC_MODE_MSB          3

`define SLPMC_SLEEP_CTRL_RESET  8'h00
`define SLPMC_STOP0_RESET       8'h00
`define SLPMC_STOP1_RESET       8'h00
`define SLPMC_STOP0_MASK        8'h2c
`define SLPMC_STOP1_MASK        8'h81

`define SLPMC_MODE_IDLE         3'h0
`define SLPMC_MODE_PDOWN        3'h2
`define SLPMC_MODE_PSAVE        3'h3
`define SLPMC_MODE_STANDBY      3'h6
`define SLPMC_MODE_EXT_STANDBY  3'h7

`define SLPMC_HALT_EXTRA_CYCLES 8'h04
`define SLPMC_STANDBY_WAKE      8'h06
`define SLPMC_STARTUP_DEFAULT   16'h0400
`define SLPMC_CNT_W             16

`endif

// ### verilog/slpmc_wake_timer.v
// down counter that times the wake-up delay
`timescale 1ns/1ps
module slpmc_wake_timer #(
    parameter CNT_W = 16
) (
    input  wire             mclk,
    input  wire             reset,
    input  wire             load,
    input  wire [CNT_W-1:0] load_value,
    output wire             done
);
    reg [CNT_W-1:0] count;
    reg             running;

    always @(posedge mclk) begin
        if (reset) begin
            count   <= {CNT_W{1'b0}};
            running <= 1'b0;
        end else if (load) begin
            count   <= load_value;
            running <= 1'b1;
        end else if (running) begin
            if (count <= {{(CNT_W-1){1'b0}}, 1'b1}) begin
                running <= 1'b0;
            end
            count <= count - {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    // a load of zero or one finishes on the following edge
    assign done = running && (count <= {{(CNT_W-1){1'b0}}, 1'b1});
endmodule

// ### test/slpmc_checker.sv
// concurrent checks on the sleep mode power controller ports
`timescale 1ns/1ps
`include "slpmc_consts.vh"
module slpmc_checker (
    input wire       mclk,
    input wire       reset,
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire       reg_write,
    input wire       sleep_instr,
    input wire       brownout_fuse_en,
    input wire       watchdog_enabled,
    input wire       debug_enable_fuse,
    input wire       cpu_clock_en,
    input wire       io_clock_en,
    input wire       osc_en,
    input wire       cpu_halt,
    input wire       wake_irq_take,
    input wire [7:0] periph_clock_en_0,
    input wire [7:0] periph_reg_block_0,
    input wire       comparator_int_ref,
    input wire       comparator_disable,
    input wire       int_ref_keep,
    input wire       brownout_keep,
    input wire       watchdog_keep,
    input wire       input_buf_en,
    input wire       wake_pin_buf_en
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    logic       arm_q;
    logic [7:0] stop0_q;
    ////////////////////////////////////////////////////////////////////////////////
    // shadow of what software wrote, so gating is tied to its cause
    always_ff @(posedge mclk) begin
        if (reset) begin
            arm_q   <= 1'b0;
            stop0_q <= 8'h00;
        end else if (reg_write && reg_addr == `SLPMC_ADDR_SLEEP_CTRL) begin
            arm_q <= reg_wdata[`SLPMC_ARM_BIT];
        end else if (reg_write && reg_addr == `SLPMC_ADDR_STOP0) begin
            stop0_q <= reg_wdata & `SLPMC_STOP0_MASK;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    reset_state_a: assert property (
        $fell(reset) |-> !cpu_halt && cpu_clock_en && osc_en && io_clock_en && !wake_irq_take)
        else $error("state after reset wrong");
    sleep_enter_a: assert property (
        sleep_instr && arm_q && !cpu_halt |=> cpu_halt && !cpu_clock_en) else $error("armed sleep not taken");
    sleep_noarm_a: assert property (
        sleep_instr && !arm_q && !cpu_halt |=> !cpu_halt && cpu_clock_en) else $error("unarmed sleep gated");
    buf_off_a: assert property (
        $fell(io_clock_en) |-> ##[0:1] (!input_buf_en && wake_pin_buf_en)) else $error("input buffers wrong");
    comp_off_a: assert property (
        $fell(io_clock_en) |-> ##[0:1] (comparator_disable == !comparator_int_ref && int_ref_keep == comparator_int_ref))
        else $error("comparator not off");
    bod_keep_a: assert property (
        brownout_fuse_en && !$past(reset) |-> brownout_keep) else $error("brown-out dropped");
    wdt_keep_a: assert property (
        watchdog_enabled && !$past(reset) |-> watchdog_keep) else $error("watchdog dropped");
    dbg_osc_a: assert property (
        debug_enable_fuse && $past(debug_enable_fuse) && !$past(reset) |-> osc_en) else $error("osc stopped");
    stop_block_a: assert property (
        $stable(stop0_q) && !$past(reset) |-> periph_reg_block_0 == stop0_q) else $error("block wrong");
    stop_resume_a: assert property (
        $stable(stop0_q) && !cpu_halt && !$past(cpu_halt) && !$past(reset) |-> periph_clock_en_0 == ~stop0_q)
        else $error("peripheral clock wrong");
    halt_four_a: assert property (
        $rose(wake_irq_take) |-> $past(cpu_halt, 1) && $past(cpu_halt, 4)) else $error("halt too short");
endmodule
bind slpmc_controller slpmc_checker i_chk (.mclk, .reset, .reg_addr, .reg_wdata, .reg_write, .sleep_instr,
    .brownout_fuse_en, .watchdog_enabled, .debug_enable_fuse, .cpu_clock_en, .io_clock_en, .osc_en, .cpu_halt,
    .wake_irq_take, .periph_clock_en_0, .periph_reg_block_0, .comparator_int_ref, .comparator_disable, .int_ref_keep,
    .brownout_keep, .watchdog_keep, .input_buf_en, .wake_pin_buf_en);

// ### test/slpmc_cpu_model.sv
// far-side model: cpu issuing sleep, interrupt sources held until taken
`timescale 1ns/1ps
module slpmc_cpu_model (
    input  wire        mclk,
    input  wire        reset,
    input  wire        req_sleep,
    input  wire [5:0]  req_wake,
    input  wire        wake_irq_take,
    output logic       sleep_instr,
    output logic [5:0] wake_lines
);
    always_ff @(posedge mclk) begin
        sleep_instr <= req_sleep & ~reset;
        // a level source stays up until the cpu takes it, so no wake is lost
        if (reset | wake_irq_take) begin
            wake_lines <= 6'h00;
        end else begin
            wake_lines <= wake_lines | req_wake;
        end
    end
endmodule

// ### test/testbench.sv
// self-checking bench for the sleep mode power controller
`timescale 1ns/1ps
`include "slpmc_consts.vh"
`define chk(nm, e, g) begin compares++; if ((g) !== (e)) begin n_fail++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module testbench;
    logic       mclk = 1'b0;
    logic       reset = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_write = 1'b0, reg_read = 1'b0, req_sleep = 1'b0, xtal = 1'b0, dbg = 1'b0;
    logic [5:0] req_wake = 6'h00;
    wire  [5:0] wl;
    wire  [7:0] reg_rdata, pe0, pe1, pb0, pb1;
    wire        sleep_instr, cpu_clk, flash_clk, io_clk, osc, halt, take, comp_dis;
    logic [7:0] d;
    logic [6:0] rows [10] = '{7'h00, 7'h12, 7'h22, 7'h32, 7'h42, 7'h52, 7'h6e, 7'h62, 7'h7e, 7'h72};
    int         n_fail = 0, compares = 0, n, lo;
    ////////////////////////////////////////////////////////////////////////////////
    slpmc_controller #(.STARTUP_CYCLES(16'h0008)) i_dut (.mclk, .reset, .reg_addr, .reg_wdata, .reg_write,
        .reg_read, .reg_rdata, .sleep_instr, .irq_pending(wl[5]), .ext_irq_lower(wl[0]), .ext_irq_upper_level(wl[1]),
        .pin_change_irq(wl[2]), .usb_wake_irq(wl[3]), .twi_addr_match(wl[4]), .crystal_selected(xtal),
        .debug_enable_fuse(dbg), .brownout_fuse_en(1'b1), .watchdog_enabled(1'b1), .comparator_int_ref(1'b0),
        .cpu_clock_en(cpu_clk), .flash_clock_en(flash_clk), .io_clock_en(io_clk), .osc_en(osc), .cpu_halt(halt),
        .wake_irq_take(take), .periph_clock_en_0(pe0), .periph_clock_en_1(pe1), .periph_reg_block_0(pb0),
        .periph_reg_block_1(pb1), .comparator_disable(comp_dis), .int_ref_keep(), .brownout_keep(),
        .watchdog_keep(), .input_buf_en(), .wake_pin_buf_en());
    slpmc_cpu_model i_cpu (.mclk, .reset, .req_sleep, .req_wake, .wake_irq_take(take), .sleep_instr,
        .wake_lines(wl));
    initial begin
        forever #25 mclk = ~mclk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic wr(input [3:0] a, input [7:0] v);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_write <= 1'b1;
        @(posedge mclk);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input [3:0] a, output [7:0] v);
        @(posedge mclk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge mclk);
        reg_read <= 1'b0;
        #1 v = reg_rdata;
    endtask
    task automatic go_sleep(input [2:0] m, input arm);
        wr(`SLPMC_ADDR_SLEEP_CTRL, {4'h0, m, arm});
        @(posedge mclk);
        req_sleep <= 1'b1;
        @(posedge mclk);
        req_sleep <= 1'b0;
        repeat (4) @(posedge mclk);
        #1;
    endtask
    task automatic wake(input [5:0] src);
        @(posedge mclk);
        req_wake <= src;
        @(posedge mclk);
        req_wake <= 6'h00;
        n = 0;
        while (take !== 1'b1 && n < 200) begin
            @(posedge mclk);
            #1 n++;
        end
    endtask
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #1000000;
        n_fail++;
        summarize;
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge mclk);
        reset <= 1'b0;
        rd(`SLPMC_ADDR_SLEEP_CTRL, d);
        `chk("ctrl_rst", `SLPMC_SLEEP_CTRL_RESET, d)
        `chk("pe0_rst", 8'hff, pe0)
        // every code, with and without crystal where it matters
        for (int i = 0; i < 10; i++) begin
            @(posedge mclk);
            xtal <= rows[i][3];
            go_sleep(rows[i][6:4], 1'b1);
            rd(`SLPMC_ADDR_STATUS, d);
            `chk("status", {3'h0, rows[i][2:0], 2'h1}, d)
            `chk("cpu_clk", 1'b0, cpu_clk | flash_clk)
            `chk("io_clk", rows[i][2:0] == 3'h0, io_clk)
            `chk("osc", rows[i][2:0] != 3'h2, osc)
            `chk("comp_dis", rows[i][2:0] != 3'h0, comp_dis)
            lo = (rows[i][2:0] == 3'h0) ? 5 : (rows[i][2:0] == 3'h6) ? 10 : 12;
            wake(rows[i][2:0] == 3'h0 ? 6'h20 : 6'h01);
            `chk("wake_time", 1'b1, n >= lo && n <= lo + 6)
            `chk("resume", 1'b1, cpu_clk & ~halt)
        end
        // reserved bits masked, unmapped reads as zero, gating follows stop bits
        wr(`SLPMC_ADDR_STOP0, 8'hff);
        wr(`SLPMC_ADDR_STOP1, 8'hff);
        rd(`SLPMC_ADDR_STOP0, d);
        `chk("stop0", `SLPMC_STOP0_MASK, d)
        rd(4'h9, d);
        `chk("unmapped", 8'h00, d)
        `chk("blk", {`SLPMC_STOP0_MASK, `SLPMC_STOP1_MASK}, {pb0, pb1})
        `chk("pen", {~`SLPMC_STOP0_MASK, ~`SLPMC_STOP1_MASK}, {pe0, pe1})
        wr(`SLPMC_ADDR_STOP0, 8'h00);
        wr(`SLPMC_ADDR_STOP1, 8'h00);
        repeat (2) @(posedge mclk);
        #1 `chk("pen_back", 16'hffff, {pe0, pe1})
        go_sleep(3'h2, 1'b0);
        `chk("noarm", 1'b1, cpu_clk & ~halt)
        // power-down ignores a plain interrupt, wakes on each listed source
        go_sleep(3'h2, 1'b1);
        @(posedge mclk);
        req_wake <= 6'h20;
        repeat (20) @(posedge mclk);
        #1 `chk("pd_irq", 1'b1, halt)
        for (int b = 0; b < 5; b++) begin
            if (b > 0) go_sleep(3'h2, 1'b1);
            wake(6'h01 << b);
            `chk("pd_src", 1'b1, n < 200)
        end
        @(posedge mclk);
        dbg <= 1'b1;
        go_sleep(3'h2, 1'b1);
        `chk("dbg_osc", 1'b1, osc)
        @(posedge mclk);
        reset <= 1'b1;
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        dbg <= 1'b0;
        rd(`SLPMC_ADDR_STATUS, d);
        `chk("rst_sleep", 3'h7, {~halt, cpu_clk, d[1:0] == 2'h0})
        summarize;
    end
endmodule
